/* hw/crc_calculation_unit.v */
// Functional notes
// - Data write folds into stored CRC
// - Data read returns latest CRC result
// - Every write size folds byte by byte
// - Data takes word, half, byte; others word
// - Four, two or one cycles per size
// - Input buffer: second write has no wait
// - Data width may change between writes
// - Input bit reversal per byte, half, word
// - Output reversal across whole word on read
// - Reset bit loads initial value, default ones
// - Initial value write loads running CRC
// - Scratch byte survives calculator reset
// - Polynomial register, width 7/8/16/32 selectable
// - Narrow CRC sits in low bits
// - Polynomial resets to Ethernet CRC-32
`include "crc_map.vh"

module crc_calculation_unit (
	input  wire        clk,
	input  wire        rst_b,
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg  [31:0] hrdata,
	output reg         hresp
);

	reg         rst_s1_r;
	reg         rst_s2_r;
	wire        rst_sync_b;

	reg         dp_act_r;
	reg         dp_wr_r;
	reg  [5:0]  dp_idx_r;
	reg  [2:0]  dp_size_r;
	reg         dp_act_nxt;
	reg         dp_wr_nxt;
	reg  [5:0]  dp_idx_nxt;
	reg  [2:0]  dp_size_nxt;

	reg  [31:0] crc_r;
	reg  [31:0] work_r;
	reg  [2:0]  left_r;
	reg         buf_v_r;
	reg  [31:0] buf_data_r;
	reg  [2:0]  buf_cnt_r;
	reg  [31:0] crc_nxt;
	reg  [31:0] work_nxt;
	reg  [2:0]  left_nxt;
	reg         buf_v_nxt;
	reg  [31:0] buf_data_nxt;
	reg  [2:0]  buf_cnt_nxt;

	reg  [7:0]  scratch_r;
	reg  [31:0] init_r;
	reg  [31:0] poly_r;
	reg  [1:0]  psize_r;
	reg  [1:0]  rin_r;
	reg         rout_r;
	reg  [7:0]  scratch_nxt;
	reg  [31:0] init_nxt;
	reg  [31:0] poly_nxt;
	reg  [1:0]  psize_nxt;
	reg  [1:0]  rin_nxt;
	reg         rout_nxt;

	reg         ready_nxt;
	reg  [31:0] rdata_nxt;
	reg         take;
	reg         load_init;
	reg         wr_ok;
	reg         idle_nxt;

	reg  [31:0] in_word;
	reg  [1:0]  in_mode;
	reg  [2:0]  in_cnt;
	reg  [31:0] in_aligned;
	wire [31:0] in_rev;
	wire [31:0] step_out;
	wire [31:0] out_rev;
	wire        accept;
	wire        done;

	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	assign rst_sync_b = rst_s2_r;

	assign accept = hsel && htrans[1] && hready;
	assign done   = dp_act_r && hready;

	// Narrow writes are right-aligned; the reversal span never exceeds
	// the access size, otherwise a byte would pick up bits of absent lanes.
	always @*
	begin
		case (dp_size_r)
			`CRC_HSIZE_BYTE:
			begin
				in_word = {24'h000000, hwdata[7:0]};
				in_mode = (rin_r == `CRC_REV_NONE) ? `CRC_REV_NONE :
				          `CRC_REV_BYTE;
				in_cnt  = `CRC_CYC_BYTE;
			end
			`CRC_HSIZE_HALF:
			begin
				in_word = {16'h0000, hwdata[15:0]};
				in_mode = (rin_r == `CRC_REV_WORD) ? `CRC_REV_HALF :
				          rin_r;
				in_cnt  = `CRC_CYC_HALF;
			end
			default:
			begin
				in_word = hwdata;
				in_mode = rin_r;
				in_cnt  = `CRC_CYC_WORD;
			end
		endcase
		// The engine always takes the top byte, so data is left-aligned.
		case (in_cnt)
			`CRC_CYC_BYTE: in_aligned = {in_rev[7:0], 24'h000000};
			`CRC_CYC_HALF: in_aligned = {in_rev[15:0], 16'h0000};
			default:       in_aligned = in_rev;
		endcase
	end

	crc_bit_reverse u_in_rev (
		.din  (in_word),
		.mode (in_mode),
		.dout (in_rev)
	);

	crc_byte_step u_step (
		.crc_in    (crc_r),
		.data_byte (work_r[31:24]),
		.poly      (poly_r),
		.width_sel (psize_r),
		.crc_out   (step_out)
	);

	always @*
	begin
		crc_nxt      = crc_r;
		work_nxt     = work_r;
		left_nxt     = left_r;
		buf_v_nxt    = buf_v_r;
		buf_data_nxt = buf_data_r;
		buf_cnt_nxt  = buf_cnt_r;
		scratch_nxt  = scratch_r;
		init_nxt     = init_r;
		poly_nxt     = poly_r;
		psize_nxt    = psize_r;
		rin_nxt      = rin_r;
		rout_nxt     = rout_r;
		load_init    = 1'b0;

		// One byte per cycle, so the widths may mix freely between writes.
		if (left_r != 3'h0)
		begin
			crc_nxt  = step_out;
			work_nxt = {work_r[23:0], 8'h00};
			left_nxt = left_r - 3'h1;
		end

		// The buffer is drained in the cycle of the last byte, so a word
		// streams in with no idle cycle between calculations.
		take = buf_v_r && (left_r <= 3'h1);
		if (take)
		begin
			work_nxt  = buf_data_r;
			left_nxt  = buf_cnt_r;
			buf_v_nxt = 1'b0;
		end

		if (done && dp_wr_r)
		begin
			case (dp_idx_r)
				`CRC_IDX_DATA:
				begin
					buf_v_nxt    = 1'b1;
					buf_data_nxt = in_aligned;
					buf_cnt_nxt  = in_cnt;
				end
				`CRC_IDX_SCRATCH:
					scratch_nxt = hwdata[7:0];
				`CRC_IDX_CTRL:
				begin
					psize_nxt = hwdata[`CRC_CTRL_PSIZE+1:`CRC_CTRL_PSIZE];
					rin_nxt   = hwdata[`CRC_CTRL_RIN+1:`CRC_CTRL_RIN];
					rout_nxt  = hwdata[`CRC_CTRL_ROUT];
					load_init = hwdata[`CRC_CTRL_RESET];
				end
				`CRC_IDX_INIT:
				begin
					init_nxt  = hwdata;
					load_init = 1'b1;
				end
				`CRC_IDX_POLY:
					poly_nxt = hwdata;
				default:
				begin
					load_init = 1'b0;
				end
			endcase
		end

		// Loading the initial value discards any calculation still queued;
		// the scratch byte is left alone.
		if (load_init)
		begin
			crc_nxt   = init_nxt;
			left_nxt  = 3'h0;
			buf_v_nxt = 1'b0;
		end

		dp_act_nxt  = dp_act_r;
		dp_wr_nxt   = dp_wr_r;
		dp_idx_nxt  = dp_idx_r;
		dp_size_nxt = dp_size_r;
		if (hready)
		begin
			dp_act_nxt  = accept;
			dp_wr_nxt   = hwrite;
			dp_idx_nxt  = haddr[7:2];
			dp_size_nxt = hsize;
		end

		// A data write may complete once the buffer is free or drains on
		// the same edge; a read waits for the engine to go quiet.
		wr_ok    = !buf_v_nxt || (left_nxt <= 3'h1);
		idle_nxt = !buf_v_nxt && (left_nxt == 3'h0);
		ready_nxt = 1'b1;
		if (dp_act_nxt && (dp_idx_nxt == `CRC_IDX_DATA))
			ready_nxt = dp_wr_nxt ? wr_ok : idle_nxt;

		case (dp_idx_nxt)
			`CRC_IDX_DATA:
				rdata_nxt = rout_nxt ? out_rev : crc_nxt;
			`CRC_IDX_SCRATCH:
				rdata_nxt = {24'h000000, scratch_nxt};
			`CRC_IDX_CTRL:
				rdata_nxt = {24'h000000, rout_nxt, rin_nxt, psize_nxt,
				             3'h0};
			`CRC_IDX_INIT:
				rdata_nxt = init_nxt;
			`CRC_IDX_POLY:
				rdata_nxt = poly_nxt;
			default:
				rdata_nxt = 32'h00000000;
		endcase
	end

	crc_bit_reverse u_out_rev (
		.din  (crc_nxt),
		.mode (`CRC_REV_WORD),
		.dout (out_rev)
	);

	always @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			dp_act_r   <= 1'b0;
			dp_wr_r    <= 1'b0;
			dp_idx_r   <= 6'h00;
			dp_size_r  <= 3'h0;
			crc_r      <= `CRC_RST_DATA;
			work_r     <= 32'h00000000;
			left_r     <= 3'h0;
			buf_v_r    <= 1'b0;
			buf_data_r <= 32'h00000000;
			buf_cnt_r  <= 3'h0;
			scratch_r  <= `CRC_RST_SCRATCH;
			init_r     <= `CRC_RST_INIT;
			poly_r     <= `CRC_RST_POLY;
			psize_r    <= `CRC_RST_PSIZE;
			rin_r      <= `CRC_RST_RIN;
			rout_r     <= 1'b0;
			hreadyout  <= 1'b1;
			hrdata     <= 32'h00000000;
			hresp      <= 1'b0;
		end
		else
		begin
			dp_act_r   <= dp_act_nxt;
			dp_wr_r    <= dp_wr_nxt;
			dp_idx_r   <= dp_idx_nxt;
			dp_size_r  <= dp_size_nxt;
			crc_r      <= crc_nxt;
			work_r     <= work_nxt;
			left_r     <= left_nxt;
			buf_v_r    <= buf_v_nxt;
			buf_data_r <= buf_data_nxt;
			buf_cnt_r  <= buf_cnt_nxt;
			scratch_r  <= scratch_nxt;
			init_r     <= init_nxt;
			poly_r     <= poly_nxt;
			psize_r    <= psize_nxt;
			rin_r      <= rin_nxt;
			rout_r     <= rout_nxt;
			hreadyout  <= ready_nxt;
			hrdata     <= rdata_nxt;
			hresp      <= 1'b0;
		end
	end

endmodule // crc_calculation_unit

/* inc/crc_map.vh */
`ifndef CRC_MAP_VH
`define CRC_MAP_VH

// Register word indices; the byte offset is four times the index.
`define CRC_IDX_DATA      6'h00
`define CRC_IDX_SCRATCH   6'h01
`define CRC_IDX_CTRL      6'h02
`define CRC_IDX_INIT      6'h04
`define CRC_IDX_POLY      6'h05

// Control register fields.
`define CRC_CTRL_RESET    0
`define CRC_CTRL_PSIZE    3
`define CRC_CTRL_RIN      5
`define CRC_CTRL_ROUT     7

// Reset values.
`define CRC_RST_DATA      32'hFFFFFFFF
`define CRC_RST_INIT      32'hFFFFFFFF
`define CRC_RST_POLY      32'h04C11DB7
`define CRC_RST_SCRATCH   8'h00
`define CRC_RST_PSIZE     2'h0
`define CRC_RST_RIN       2'h0

// Polynomial width codes.
`define CRC_PSIZE_32      2'h0
`define CRC_PSIZE_16      2'h1
`define CRC_PSIZE_8       2'h2
`define CRC_PSIZE_7       2'h3

// Input reversal codes.
`define CRC_REV_NONE      2'h0
`define CRC_REV_BYTE      2'h1
`define CRC_REV_HALF      2'h2
`define CRC_REV_WORD      2'h3

// Bus access sizes.
`define CRC_HSIZE_BYTE    3'h0
`define CRC_HSIZE_HALF    3'h1

// Cycles of calculation per access size, one byte per cycle.
`define CRC_CYC_WORD      3'h4
`define CRC_CYC_HALF      3'h2
`define CRC_CYC_BYTE      3'h1

`endif

/* hw/crc_bit_reverse.v */
`include "crc_map.vh"

module crc_bit_reverse (
	input  wire [31:0] din,
	input  wire [1:0]  mode,
	output wire [31:0] dout
);

	genvar i;
	generate
		for (i = 0; i < 32; i = i + 1)
		begin : g_bit
			assign dout[i] = (mode == `CRC_REV_BYTE) ? din[i ^ 7]  :
			                 (mode == `CRC_REV_HALF) ? din[i ^ 15] :
			                 (mode == `CRC_REV_WORD) ? din[i ^ 31] :
			                 din[i];
		end
	endgenerate

endmodule // crc_bit_reverse

/* hw/crc_byte_step.v */
`include "crc_map.vh"

module crc_byte_step (
	input  wire [31:0] crc_in,
	input  wire [7:0]  data_byte,
	input  wire [31:0] poly,
	input  wire [1:0]  width_sel,
	output wire [31:0] crc_out
);

	reg  [4:0]  sh;
	wire [31:0] poly_al;
	wire [31:0] stage [0:8];

	// Narrow CRCs are worked left-aligned so one shifter serves all widths.
	always @*
	begin
		case (width_sel)
			`CRC_PSIZE_32: sh = 5'h00;
			`CRC_PSIZE_16: sh = 5'h10;
			`CRC_PSIZE_8:  sh = 5'h18;
			default:       sh = 5'h19;
		endcase
	end

	assign poly_al  = poly << sh;
	assign stage[0] = (crc_in << sh) ^ {data_byte, 24'h000000};

	genvar k;
	generate
		for (k = 0; k < 8; k = k + 1)
		begin : g_step
			assign stage[k + 1] = stage[k][31] ?
				({stage[k][30:0], 1'b0} ^ poly_al) :
				{stage[k][30:0], 1'b0};
		end
	endgenerate

	assign crc_out = stage[8] >> sh;

endmodule // crc_byte_step

/* verification/crc_calculation_unit_assertions.sv */
module crc_unit_checker (
	input logic        clk,
	input logic        rst_b,
	input logic        hsel,
	input logic [7:0]  haddr,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic        hready,
	input logic        hreadyout,
	input logic [31:0] hrdata,
	input logic        hresp
);
	timeunit 1ns;
	timeprecision 1ps;
	// Data phase as {valid, write, index}; idle_r saturates once surely idle.
	logic [7:0] dp_r;
	logic [3:0] idle_r;
	wire  [5:0] idx = dp_r[5:0];
	wire        dat = dp_r[7] && idx == 6'h00;
	wire        oth = dp_r[7] && idx != 6'h00;
	wire        rdo = dp_r[7:6] == 2'h2 && hreadyout;
	always @(posedge clk or negedge rst_b)
		if (!rst_b)
			{dp_r, idle_r} <= 12'h00F;
		else
		begin
			if (hready)
				dp_r <= {hsel && htrans[1], hwrite, haddr[7:2]};
			if (dat && dp_r[6] && hready)
				idle_r <= 4'h0;
			else if (idle_r != 4'hF)
				idle_r <= idle_r + 4'h1;
		end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_okay; !hresp; endproperty
	a_okay: assert property (p_okay) else $error("hresp");
	property p_other; oth |-> hreadyout; endproperty
	a_other: assert property (p_other) else $error("stall");
	property p_scr; rdo && idx == 6'h01 |-> hrdata[31:8] == 24'h0;
	endproperty
	a_scr: assert property (p_scr) else $error("scratch");
	property p_ctl; rdo && idx == 6'h02 |-> !hrdata[0]; endproperty
	a_ctl: assert property (p_ctl) else $error("ctrl");
	property p_unmap; rdo && (idx == 6'h03 || idx > 6'h05) |-> hrdata == 0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped");
	property p_wr; dat && dp_r[6] |-> ##[0:4] hreadyout; endproperty
	a_wr: assert property (p_wr) else $error("write wait");
	property p_rd; dat && !dp_r[6] |-> ##[0:8] hreadyout; endproperty
	a_rd: assert property (p_rd) else $error("read wait");
	property p_idle; dat && !dp_r[6] && idle_r == 4'hF |-> hreadyout;
	endproperty
	a_idle: assert property (p_idle) else $error("idle read");
endmodule // crc_unit_checker

bind crc_calculation_unit crc_unit_checker crc_unit_checker_inst (.clk,
	.rst_b, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hrdata,
	.hresp);

/* verification/ahb_master.sv */
module ahb_master (
	input  logic        clk,
	input  logic        hreadyout,
	input  logic [31:0] hrdata,
	output logic        hsel,
	output logic [7:0]  haddr,
	output logic [1:0]  htrans,
	output logic        hwrite,
	output logic [2:0]  hsize,
	output logic [31:0] hwdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// Entries are {write, size, address, data}; results sit one slot late.
	logic [43:0] q [$];
	logic [31:0] got [$];
	int          waits [$];
	initial
		{hsel, htrans, hwrite, hsize, haddr, hwdata} = 47'h0;
	task automatic run();
		// Results are indexed per run, so earlier runs must not linger.
		got = {};
		waits = {};
		for (int k = 0; k <= q.size(); k++)
		begin
			@(negedge clk);
			if (k > 0)
				hwdata = q[k-1][31:0];
			hsel = k < q.size();
			htrans = {hsel, 1'b0};
			if (hsel)
				{hwrite, hsize, haddr} = q[k][43:32];
			waits.push_back(0);
			@(posedge clk);
			while (!hreadyout)
			begin
				waits[k]++;
				@(posedge clk);
			end
			got.push_back(hrdata);
		end
		q = {};
		@(negedge clk);
		hwdata = ~hwdata;
	endtask
endmodule // ahb_master

/* verification/crc_calculation_unit_tb_top.sv */
module crc_calculation_unit_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_b, hsel, hwrite, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  haddr;
	logic [31:0] hwdata, hrdata, poly = 32'h04C11DB7;
	logic [31:0] crc = 32'hFFFFFFFF, msk = 32'hFFFFFFFF;
	int          wd = 32, cycles, mismatches, checks_done;
	crc_calculation_unit crc_calculation_unit_inst (.clk, .rst_b, .hsel,
		.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hreadyout, .hrdata, .hresp);
	ahb_master ahb_master_inst (.clk, .hreadyout, .hrdata, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata);
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
		if (++cycles == 8000)
		begin
			mismatches++;
			complete_run();
		end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic op(input logic [43:0] o);
		ahb_master_inst.q.push_back(o);
	endtask
	task automatic go(input logic [43:0] o);
		op(o);
		ahb_master_inst.run();
	endtask
	task automatic rc(input string nm, input logic [7:0] a, logic [31:0] e);
		go({4'h2, a, 32'h0});
		chk(nm, e, ahb_master_inst.got[1]);
	endtask
	// Reference fold, MSB first, high byte first, within the low wd bits.
	task automatic feed(input logic [31:0] d, input int n);
		for (int i = 8 * n - 1; i >= 0; i--)
			crc = ((crc << 1) ^ (crc[wd-1] ^ d[i] ? poly : 32'h0)) & msk;
	endtask
	task automatic s_stream();
		op({4'hA, 8'h00, 32'h1A2B3C4D});
		op({4'hA, 8'h00, 32'h11223344});
		op({4'h8, 8'h00, 32'h00000055});
		op({4'h9, 8'h00, 32'h0000BEEF});
		op({4'h2, 8'h00, 32'h0});
		ahb_master_inst.run();
		feed(32'h1A2B3C4D, 4);
		feed(32'h11223344, 4);
		feed(32'h55, 1);
		feed(32'hBEEF, 2);
		chk("wait2", 32'h0, ahb_master_inst.waits[2]);
		chk("stall3", 32'h1, ahb_master_inst.waits[3] > 0);
		chk("crc", crc, ahb_master_inst.got[5]);
	endtask
	task automatic s_rev();
		logic [31:0] rv [3] = '{32'h58D43CB2, 32'hD458B23C, 32'hB23CD458};
		logic [31:0] flip;
		for (int k = 1; k <= 3; k++)
		begin
			go({4'hA, 8'h08, 32'h01 | (k << 5)});
			go({4'hA, 8'h00, 32'h1A2B3C4D});
			crc = 32'hFFFFFFFF;
			feed(rv[k-1], 4);
			rc("input_reverse_select", 8'h00, crc);
		end
		// Word reversal on narrow accesses shrinks to the access size.
		go({4'hA, 8'h08, 32'h00000061});
		go({4'h9, 8'h00, 32'h00003C4D});
		go({4'h8, 8'h00, 32'h0000004D});
		crc = 32'hFFFFFFFF;
		feed(32'hB23C, 2);
		feed(32'hB2, 1);
		rc("rev_narrow", 8'h00, crc);
		go({4'hA, 8'h08, 32'h80});
		for (int i = 0; i < 32; i++)
			flip[i] = crc[31 - i];
		rc("output_reverse_enable", 8'h00, flip);
	endtask
	task automatic s_misc();
		rc("poly_rst", 8'h14, 32'h04C11DB7);
		rc("init_rst", 8'h10, 32'hFFFFFFFF);
		go({4'hA, 8'h04, 32'h000000C3});
		go({4'hA, 8'h08, 32'h01});
		rc("scratch", 8'h04, 32'h000000C3);
		rc("ctrl", 8'h08, 32'h0);
		go({4'hA, 8'h10, 32'h12345678});
		rc("init", 8'h00, 32'h12345678);
		rc("unmapped", 8'hFC, 32'h0);
	endtask
	task automatic s_narrow();
		logic [31:0] pl [3] = '{32'h1021, 32'h07, 32'h09};
		for (int k = 1; k <= 3; k++)
		begin
			wd = (k == 1) ? 16 : 10 - k;
			msk = 32'hFFFFFFFF >> (32 - wd);
			poly = pl[k-1];
			crc = msk;
			go({4'hA, 8'h08, k << 3});
			go({4'hA, 8'h14, poly});
			go({4'hA, 8'h10, msk});
			feed(32'hA5, 1);
			go({4'h8, 8'h00, 32'h000000A5});
			rc("narrow", 8'h00, crc);
		end
	endtask
	initial
	begin
		rst_b = 1'b0;
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(posedge clk);
		s_stream();
		s_rev();
		s_misc();
		s_narrow();
		complete_run();
	end
endmodule // crc_calculation_unit_tb_top
